// >>> rtl/bst_params.svh
/*
  Constants of the boundary-scan test port: register widths, opcodes,
  capture values and the test-clock timing of the host end.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

`define BST_IR_W 3
`define BST_ID_W 32
`define BST_BSR_W 109
`define BST_OE_CELL 108
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE_Z 3'h2
`define BST_OP_SAMPLE_PRELOAD 3'h4
`define BST_OP_BYPASS 3'h7
`define BST_IR_CAPTURE 2'h1
`define BST_ID_DEFAULT 32'h0a5a_5001
`define BST_MCLK_NS 100
`define BST_TCK_NS 800
`define BST_TCK_HALF ((`BST_TCK_NS / 2) / `BST_MCLK_NS)
`define BST_DIV_W 4
`define BST_XFER_W 128
`define BST_LEN_W 8
`define BST_PRE_RST 3'h6
`define BST_PRE_IR 3'h4
`define BST_PRE_DR 3'h3
`define BST_PAT_RST 6'h1f
`define BST_PAT_IR 6'h03
`define BST_PAT_DR 6'h01
`define BST_POST 8'h02

`endif

// >>> rtl/bst_pkg.sv
/*
  Types shared by both ends of the boundary-scan test port.
  Assumes bst_params.svh is compiled alongside.
*/
package bst_pkg;
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
  } bst_tap_e;
  typedef enum logic [2:0] {
    DR_BYP = 3'h1, DR_ID = 3'h2, DR_BSR = 3'h4
  } bst_dr_e;
  typedef enum logic [1:0] {
    KIND_RESET = 2'h0, KIND_IR = 2'h1, KIND_DR = 2'h2
  } bst_kind_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'h1, H_RUN = 2'h2
  } bst_host_e;
endpackage

// >>> rtl/bst_if.sv
/*
  Test-port link between the board controller and the device.
  Mode select and data-in read high when the controller releases them.
*/
`timescale 1ns/1ps
`default_nettype none
interface bst_if;
  logic tck;
  logic tms;
  logic tms_oe_n;
  logic tdi;
  logic tdi_oe_n;
  logic tdo;
  logic tdo_oe_n;
  logic tms_line;
  logic tdi_line;
  // Internal pull-ups of the device pins
  assign tms_line = tms_oe_n ? 1'b1 : tms;
  assign tdi_line = tdi_oe_n ? 1'b1 : tdi;
  modport dev (input tck, input tms_line, input tdi_line, output tdo, output tdo_oe_n);
  modport host (output tck, output tms, output tms_oe_n, output tdi, output tdi_oe_n,
                input tdo, input tdo_oe_n);
endinterface
`default_nettype wire

// >>> rtl/bst_tap_dev.sv
/*
  Device end of the boundary-scan test port: TAP state machine,
  instruction, bypass, identification and boundary scan registers.
  Assumes the test clock, mode select and data-in are asynchronous to
  mclk_i and slower than a quarter of it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_params.svh"
// Contract
// - Sixteen-state TAP sequence steered by mode select
// - Unused port keeps test clock low
// - Power-up reset state leaves memory undisturbed
// - Sample on clock rise, drive on fall
// - Mode select and data-in pulled high
// - Instruction selects exactly one data register
// - Shift in at MSB, out at LSB
// - Data-out enabled only in shift states
// - Five high mode-select edges reset port
// - Power-up reset floats data-out
// - Three-bit instruction, identification loaded at reset
// - Capture-IR loads 01 into low bits
// - One-bit bypass captures low
// - Boundary register captures pins, shifts in Shift-DR
// - Extest, preload, sample-z capture the pin ring
// - Identification captures fixed 32-bit code
// - Controller never loads reserved codes
// - New instruction takes effect at Update-IR
// - Sample-z floats read bus until next update
// - Cell 108 drives bus enable, preset high
// - Preload shifts in while capture shifts out
// - Extest drives preloaded values onto pins
module bst_tap_dev #(
  parameter logic [`BST_ID_W-1:0] ID_CODE = `BST_ID_DEFAULT // Value is arbitrary
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  bst_if.dev tap,
  input wire logic [`BST_BSR_W-1:0] pin_ring_i,
  output logic [`BST_BSR_W-1:0] pin_drive_o,
  output logic extest_o,
  output logic q_oe_o,
  output logic [`BST_IR_W-1:0] ir_o
);
  localparam logic [`BST_BSR_W-1:0] BSR_ONE = {{(`BST_BSR_W-1){1'b0}}, 1'b1};
  localparam logic [`BST_BSR_W-1:0] PRE_RESET = BSR_ONE << `BST_OE_CELL;

  function automatic bst_pkg::bst_tap_e tap_next(input bst_pkg::bst_tap_e s, input logic m);
    tap_next = s;
    case (s)
      bst_pkg::ST_TLR: tap_next = m ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: tap_next = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: tap_next = m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: tap_next = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: tap_next = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: tap_next = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: tap_next = m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: tap_next = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: tap_next = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      // Five ones from any state end in reset
      bst_pkg::ST_SEL_IR: tap_next = m ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: tap_next = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: tap_next = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: tap_next = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: tap_next = m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: tap_next = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: tap_next = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      default: tap_next = bst_pkg::ST_TLR;
    endcase
  endfunction

  function automatic bst_pkg::bst_dr_e dr_sel(input logic [`BST_IR_W-1:0] op);
    dr_sel = bst_pkg::DR_BYP;
    if (op == `BST_OP_IDCODE) begin
      dr_sel = bst_pkg::DR_ID;
    end else if (op == `BST_OP_EXTEST || op == `BST_OP_SAMPLE_PRELOAD ||
                 op == `BST_OP_SAMPLE_Z) begin
      dr_sel = bst_pkg::DR_BSR;
    end
  endfunction

  logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
  logic [`BST_BSR_W-1:0] pin_s1, pin_s2;
  logic tck_rise, tck_fall;
  bst_pkg::bst_tap_e state_reg, state_next;
  bst_pkg::bst_dr_e sel;
  logic [`BST_IR_W-1:0] ir_reg, ir_next, ir_sr_reg, ir_sr_next;
  logic byp_reg, byp_next;
  logic [`BST_ID_W-1:0] id_sr_reg, id_sr_next;
  logic [`BST_BSR_W-1:0] bsr_reg, bsr_next, pre_reg, pre_next;
  logic tdo_reg, tdo_next, tdo_oe_n_reg, tdo_oe_n_next;
  logic q_oe_reg, q_oe_next, extest_reg, extest_next;

  // Edge detect reads only the second and third stages
  assign tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall = ~tck_s2 & tck_s3;
  assign sel = dr_sel(ir_reg);

  always_comb begin
    state_next = state_reg;
    ir_next = ir_reg;
    ir_sr_next = ir_sr_reg;
    byp_next = byp_reg;
    id_sr_next = id_sr_reg;
    bsr_next = bsr_reg;
    pre_next = pre_reg;
    tdo_next = tdo_reg;
    tdo_oe_n_next = tdo_oe_n_reg;
    if (tck_rise) begin
      state_next = tap_next(state_reg, tms_s2);
      case (state_reg)
        bst_pkg::ST_CAP_IR: begin
          ir_sr_next = {{(`BST_IR_W-2){1'b0}}, `BST_IR_CAPTURE};
        end
        bst_pkg::ST_SH_IR: begin
          ir_sr_next = {tdi_s2, ir_sr_reg[`BST_IR_W-1:1]};
        end
        bst_pkg::ST_CAP_DR: begin
          if (sel == bst_pkg::DR_BYP) begin
            byp_next = 1'b0;
          end else if (sel == bst_pkg::DR_ID) begin
            id_sr_next = ID_CODE;
          end else begin
            bsr_next = pin_s2;
          end
        end
        bst_pkg::ST_SH_DR: begin
          if (sel == bst_pkg::DR_BYP) begin
            byp_next = tdi_s2;
          end else if (sel == bst_pkg::DR_ID) begin
            id_sr_next = {tdi_s2, id_sr_reg[`BST_ID_W-1:1]};
          end else begin
            bsr_next = {tdi_s2, bsr_reg[`BST_BSR_W-1:1]};
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      case (state_reg)
        bst_pkg::ST_TLR: begin
          ir_next = `BST_OP_IDCODE;
          pre_next[`BST_OE_CELL] = 1'b1;
        end
        bst_pkg::ST_UPD_IR: begin
          ir_next = ir_sr_reg;
        end
        bst_pkg::ST_UPD_DR: begin
          if (sel == bst_pkg::DR_BSR) begin
            pre_next = bsr_reg;
          end
        end
        default: begin
        end
      endcase
      if (state_reg == bst_pkg::ST_SH_IR) begin
        tdo_next = ir_sr_reg[0];
      end else if (sel == bst_pkg::DR_BYP) begin
        tdo_next = byp_reg;
      end else if (sel == bst_pkg::DR_ID) begin
        tdo_next = id_sr_reg[0];
      end else begin
        tdo_next = bsr_reg[0];
      end
      tdo_oe_n_next = ~(state_reg == bst_pkg::ST_SH_IR ||
                        state_reg == bst_pkg::ST_SH_DR);
    end
    extest_next = (ir_reg == `BST_OP_EXTEST);
    if (ir_reg == `BST_OP_SAMPLE_Z) begin
      q_oe_next = 1'b0;
    end else if (ir_reg == `BST_OP_EXTEST) begin
      q_oe_next = pre_reg[`BST_OE_CELL];
    end else begin
      q_oe_next = 1'b1;
    end
  end

  // Reset leaves the memory path in normal mode with data-out floating
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      pin_s1 <= '0;
      pin_s2 <= '0;
      state_reg <= bst_pkg::ST_TLR;
      ir_reg <= `BST_OP_IDCODE;
      ir_sr_reg <= `BST_OP_IDCODE;
      byp_reg <= 1'b0;
      id_sr_reg <= '0;
      bsr_reg <= '0;
      pre_reg <= PRE_RESET;
      tdo_reg <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
      q_oe_reg <= 1'b1;
      extest_reg <= 1'b0;
    end else begin
      tck_s1 <= tap.tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tap.tms_line;
      tms_s2 <= tms_s1;
      tdi_s1 <= tap.tdi_line;
      tdi_s2 <= tdi_s1;
      // Pins may move during capture; the value taken is then undefined
      pin_s1 <= pin_ring_i;
      pin_s2 <= pin_s1;
      state_reg <= state_next;
      ir_reg <= ir_next;
      ir_sr_reg <= ir_sr_next;
      byp_reg <= byp_next;
      id_sr_reg <= id_sr_next;
      bsr_reg <= bsr_next;
      pre_reg <= pre_next;
      tdo_reg <= tdo_next;
      tdo_oe_n_reg <= tdo_oe_n_next;
      q_oe_reg <= q_oe_next;
      extest_reg <= extest_next;
    end
  end

  assign tap.tdo = tdo_reg;
  assign tap.tdo_oe_n = tdo_oe_n_reg;
  assign pin_drive_o = pre_reg;
  assign extest_o = extest_reg;
  assign q_oe_o = q_oe_reg;
  assign ir_o = ir_reg;
endmodule
`default_nettype wire

// >>> rtl/bst_tap_host.sv
/*
  Board controller end: makes the test clock by dividing mclk_i and
  walks the TAP through reset, instruction and data scans.
  Assumes every scan starts and ends in Run-Test/Idle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_params.svh"
module bst_tap_host (
  input wire logic mclk_i,
  input wire logic rst_i,
  bst_if.host tap,
  input wire logic start_i,
  input wire logic [1:0] kind_i,
  input wire logic [`BST_LEN_W-1:0] len_i,
  input wire logic [`BST_XFER_W-1:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic [`BST_XFER_W-1:0] rx_data_o
);
  localparam logic [`BST_DIV_W-1:0] HALF_LAST = `BST_DIV_W'(`BST_TCK_HALF - 1);

  // Mode-select level for bit index i of a scan
  function automatic logic tms_at(input logic [7:0] i, input logic [2:0] pre,
                                  input logic [7:0] len, input logic [5:0] pat);
    logic [7:0] p;
    p = {5'h0, pre};
    if (i < p) begin
      tms_at = pat[i[2:0]];
    end else if (i < p + len) begin
      tms_at = (i == p + len - 8'h1);
    end else begin
      tms_at = (i == p + len);
    end
  endfunction

  bst_pkg::bst_host_e state_reg, state_next;
  logic tck_reg, tck_next, tms_reg, tms_next, tdi_reg, tdi_next, oe_n_reg, oe_n_next;
  logic done_reg, done_next, tdo_s1, tdo_s2;
  logic [`BST_DIV_W-1:0] div_reg, div_next;
  logic [7:0] idx_reg, idx_next, total_reg, total_next, len_reg, len_next;
  logic [7:0] sidx, nidx;
  logic [2:0] pre_reg, pre_next;
  logic [5:0] pat_reg, pat_next;
  logic [`BST_XFER_W-1:0] data_reg, data_next, rx_reg, rx_next;

  assign sidx = idx_reg - {5'h0, pre_reg};
  assign nidx = idx_reg + 8'h1 - {5'h0, pre_reg};

  always_comb begin
    state_next = state_reg;
    tck_next = tck_reg;
    tms_next = tms_reg;
    tdi_next = tdi_reg;
    oe_n_next = oe_n_reg;
    done_next = 1'b0;
    div_next = div_reg;
    idx_next = idx_reg;
    total_next = total_reg;
    len_next = len_reg;
    pre_next = pre_reg;
    pat_next = pat_reg;
    data_next = data_reg;
    rx_next = rx_reg;
    case (state_reg)
      bst_pkg::H_IDLE: begin
        tck_next = 1'b0;
        if (start_i) begin
          if (kind_i == bst_pkg::KIND_RESET) begin
            pre_next = `BST_PRE_RST;
            pat_next = `BST_PAT_RST;
            len_next = 8'h0;
            total_next = {5'h0, `BST_PRE_RST};
          end else begin
            pre_next = (kind_i == bst_pkg::KIND_IR) ? `BST_PRE_IR : `BST_PRE_DR;
            pat_next = (kind_i == bst_pkg::KIND_IR) ? `BST_PAT_IR : `BST_PAT_DR;
            len_next = len_i;
            total_next = {5'h0, pre_next} + len_i + `BST_POST;
          end
          data_next = data_i;
          rx_next = '0;
          idx_next = 8'h0;
          div_next = '0;
          tms_next = tms_at(8'h0, pre_next, len_next, pat_next);
          tdi_next = 1'b1;
          oe_n_next = 1'b0;
          state_next = bst_pkg::H_RUN;
        end
      end
      bst_pkg::H_RUN: begin
        if (div_reg == HALF_LAST) begin
          div_next = '0;
          tck_next = ~tck_reg;
          if (tck_reg) begin
            // Device drives on the previous fall; sampling just before ours is safe
            if (idx_reg >= {5'h0, pre_reg} && sidx < len_reg) begin
              rx_next[sidx[6:0]] = tdo_s2;
            end
            idx_next = idx_reg + 8'h1;
            if (idx_next == total_reg) begin
              state_next = bst_pkg::H_IDLE;
              oe_n_next = 1'b1;
              done_next = 1'b1;
            end else begin
              tms_next = tms_at(idx_next, pre_reg, len_reg, pat_reg);
              tdi_next = (idx_next >= {5'h0, pre_reg} && nidx < len_reg) ?
                         data_reg[nidx[6:0]] : 1'b1;
            end
          end
        end else begin
          div_next = div_reg + 1'b1;
        end
      end
      default: state_next = bst_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= bst_pkg::H_IDLE;
      tck_reg <= 1'b0;
      tms_reg <= 1'b1;
      tdi_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      tdo_s1 <= 1'b1;
      tdo_s2 <= 1'b1;
      div_reg <= '0;
      idx_reg <= 8'h0;
      total_reg <= 8'h0;
      len_reg <= 8'h0;
      pre_reg <= 3'h0;
      pat_reg <= 6'h0;
      data_reg <= '0;
      rx_reg <= '0;
    end else begin
      state_reg <= state_next;
      tck_reg <= tck_next;
      tms_reg <= tms_next;
      tdi_reg <= tdi_next;
      oe_n_reg <= oe_n_next;
      done_reg <= done_next;
      tdo_s1 <= tap.tdo_oe_n ? 1'b1 : tap.tdo;
      tdo_s2 <= tdo_s1;
      div_reg <= div_next;
      idx_reg <= idx_next;
      total_reg <= total_next;
      len_reg <= len_next;
      pre_reg <= pre_next;
      pat_reg <= pat_next;
      data_reg <= data_next;
      rx_reg <= rx_next;
    end
  end

  assign tap.tck = tck_reg;
  assign tap.tms = tms_reg;
  assign tap.tms_oe_n = oe_n_reg;
  assign tap.tdi = tdi_reg;
  assign tap.tdi_oe_n = oe_n_reg;
  assign busy_o = (state_reg == bst_pkg::H_RUN);
  assign done_o = done_reg;
  assign rx_data_o = rx_reg;
endmodule
`default_nettype wire

// >>> bench/bst_tap_props.sv
/*
  Checker of the test-port link: follows the TAP state from the wire and
  checks what the device end answers on data-out.
  Assumes the bench ties it to the link shared by the two ends.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_params.svh"
module bst_tap_chk #(
  parameter logic [`BST_ID_W-1:0] ID_CODE = `BST_ID_DEFAULT // Value is arbitrary
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tck,
  input wire logic tms_line,
  input wire logic tdi_line,
  input wire logic tms_oe_n,
  input wire logic tdi_oe_n,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // State index follows the bit order of the package enum, reset state = 0
  localparam logic [3:0] N0 [16] = '{4'h1, 4'h1, 4'h3, 4'h4, 4'h4, 4'h6, 4'h6, 4'h4,
    4'h1, 4'ha, 4'hb, 4'hb, 4'hd, 4'hd, 4'hb, 4'h1};
  localparam logic [3:0] N1 [16] = '{4'h0, 4'h2, 4'h9, 4'h5, 4'h5, 4'h8, 4'h7, 4'h8,
    4'h2, 4'h0, 4'hc, 4'hc, 4'hf, 4'he, 4'hf, 4'h2};
  logic tck_reg, oe_reg, oe_next, tdip_reg, tdip_next, rise, fall, byp, id_sel;
  logic [3:0] st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] sh_reg, sh_next, ir_reg, ir_next;
  assign rise = tck & ~tck_reg;
  assign fall = ~tck & tck_reg;
  // Reserved codes fall back to the bypass path
  assign byp = !(ir_reg inside {`BST_OP_EXTEST, `BST_OP_IDCODE, `BST_OP_SAMPLE_Z,
    `BST_OP_SAMPLE_PRELOAD});
  assign id_sel = ir_reg == `BST_OP_IDCODE;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ir_next = ir_reg;
    tdip_next = tdip_reg;
    oe_next = oe_reg;
    if (rise) begin
      st_next = tms_line ? N1[st_reg] : N0[st_reg];
      if (st_reg == 4'h4 || st_reg == 4'hb) begin
        cnt_next = cnt_reg + 8'h01;
        tdip_next = tdi_line;
      end
      if (st_reg == 4'hb) sh_next = {tdi_line, sh_reg[2:1]};
    end
    if (st_reg == 4'h3 || st_reg == 4'ha) cnt_next = 8'h00;
    if (st_reg == 4'hf) ir_next = sh_reg;
    if (st_reg == 4'h0) ir_next = `BST_OP_IDCODE;
    if (fall) oe_next = !(st_reg == 4'h4 || st_reg == 4'hb);
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tck_reg <= 1'b0;
      oe_reg <= 1'b1;
      tdip_reg <= 1'b0;
      st_reg <= 4'h0;
      cnt_reg <= 8'h00;
      sh_reg <= 3'h0;
      ir_reg <= `BST_OP_IDCODE;
    end else begin
      tck_reg <= tck;
      oe_reg <= oe_next;
      tdip_reg <= tdip_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ir_reg <= ir_next;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_dr_shift;
    rise && st_reg == 4'h4;
  endsequence
  sequence s_ir_shift;
    rise && st_reg == 4'hb;
  endsequence
  // Data-out settles a few clocks after the test clock falls
  property p_oe_state; $fell(tck) |-> ##6 (tdo_oe_n == oe_reg); endproperty
  a_oe_state: assert property (p_oe_state) else $error("data-out enable wrong");
  property p_tdo_fall; $changed(tdo) |-> !$past(tck, 2); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("data-out moved in high phase");
  property p_in_stable;
    $changed({tms_line, tdi_line}) |-> $fell(tck) || $changed({tms_oe_n, tdi_oe_n});
  endproperty
  a_in_stable: assert property (p_in_stable) else $error("inputs moved off tck fall");
  property p_tck_idle; tms_oe_n |-> !tck; endproperty
  a_tck_idle: assert property (p_tck_idle) else $error("test clock runs while unused");
  property p_rst_float; $fell(rst_i) |-> tdo_oe_n && !tck; endproperty
  a_rst_float: assert property (p_rst_float) else $error("data-out driven at reset");
  property p_capir; s_ir_shift ##0 (cnt_reg < 8'h02) |-> tdo == (cnt_reg == 8'h00); endproperty
  a_capir: assert property (p_capir) else $error("capture pattern wrong");
  property p_idcode;
    s_dr_shift ##0 (id_sel && cnt_reg < 8'h20) |-> tdo == ID_CODE[cnt_reg[4:0]];
  endproperty
  a_idcode: assert property (p_idcode) else $error("identification bit wrong");
  property p_byp_zero; s_dr_shift ##0 (byp && cnt_reg == 8'h00) |-> !tdo; endproperty
  a_byp_zero: assert property (p_byp_zero) else $error("bypass capture not low");
  property p_byp_delay; s_dr_shift ##0 (byp && cnt_reg != 8'h00) |-> tdo == tdip_reg; endproperty
  a_byp_delay: assert property (p_byp_delay) else $error("bypass path not one bit");
endmodule
`default_nettype wire

// >>> bench/tb_boundary_scan_test_port.sv
/*
  Testbench: host end drives the device end; a queue model predicts scans.
  Assumes the rtl folder is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_params.svh"
module tb_boundary_scan_test_port;
  localparam logic [31:0] ID_VAL = 32'h3c3c_0ff1; // Value is arbitrary
  // Reserved codes stay out of the stimulus; the controller may never load them
  localparam logic [2:0] OPS [8] = '{`BST_OP_SAMPLE_PRELOAD, `BST_OP_EXTEST, `BST_OP_SAMPLE_Z,
    `BST_OP_BYPASS, `BST_OP_EXTEST, `BST_OP_SAMPLE_PRELOAD, `BST_OP_BYPASS, `BST_OP_IDCODE};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [1:0] kind_i = 2'h0;
  logic [7:0] len_i = 8'h00;
  logic [127:0] data_i = '0;
  logic [108:0] pin_ring_i = '0;
  logic busy_o, done_o, extest_o, q_oe_o;
  logic [127:0] rx_data_o;
  logic [108:0] pin_drive_o, m_drive;
  logic [2:0] ir_o, m_ir;
  int err_total = 0;
  int tests_run = 0;
  integer seed = 32'hc858;
  bit mq[$];
  bst_if tap ();
  always #50 mclk_i = ~mclk_i;
  bst_tap_dev #(.ID_CODE(ID_VAL)) bst_tap_dev_inst (.mclk_i(mclk_i), .rst_i(rst_i), .tap(tap),
    .pin_ring_i(pin_ring_i), .pin_drive_o(pin_drive_o), .extest_o(extest_o), .q_oe_o(q_oe_o),
    .ir_o(ir_o));
  bst_tap_host bst_tap_host_inst (.mclk_i(mclk_i), .rst_i(rst_i), .tap(tap), .start_i(start_i),
    .kind_i(kind_i), .len_i(len_i), .data_i(data_i), .busy_o(busy_o), .done_o(done_o),
    .rx_data_o(rx_data_o));
  bst_tap_chk #(.ID_CODE(ID_VAL)) bst_tap_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .tck(tap.tck), .tms_line(tap.tms_line), .tdi_line(tap.tdi_line), .tms_oe_n(tap.tms_oe_n),
    .tdi_oe_n(tap.tdi_oe_n), .tdo(tap.tdo), .tdo_oe_n(tap.tdo_oe_n));
  function automatic logic [127:0] rnd();
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_scan(input string nm, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_out(input string nm, input logic [108:0] e, input logic [108:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic check_out();
    logic q;
    logic [4:0] ctl_e;
    q = (m_ir == `BST_OP_SAMPLE_Z) ? 1'b0 : (m_ir == `BST_OP_EXTEST) ? m_drive[108] : 1'b1;
    ctl_e = {m_ir, q, m_ir == `BST_OP_EXTEST};
    cmp_out("ctl", 109'(ctl_e), 109'({ir_o, q_oe_o, extest_o}));
    cmp_out("drive", m_drive, pin_drive_o);
    cmp_out("float", 109'h1, 109'(tap.tdo_oe_n));
    cmp_out("idle", 109'h0, 109'({busy_o, tap.tck}));
  endtask
  // Model shifts a queue: captured bits leave from the front, data-in joins the back
  task automatic scan(input logic [1:0] k, input int n, input logic [127:0] d);
    logic [127:0] e;
    logic [2:0] ir_old;
    bit seen;
    int t;
    e = '0;
    ir_old = ir_o;
    seen = 1'b0;
    mq.delete();
    if (k == bst_pkg::KIND_IR) for (int i = 0; i < 3; i++) mq.push_back(i == 0);
    else if (m_ir == `BST_OP_IDCODE) for (int i = 0; i < 32; i++) mq.push_back(ID_VAL[i]);
    else if (m_ir inside {`BST_OP_EXTEST, `BST_OP_SAMPLE_Z, `BST_OP_SAMPLE_PRELOAD})
      for (int i = 0; i < 109; i++) mq.push_back(pin_ring_i[i]);
    else mq.push_back(1'b0);
    for (int i = 0; i < n; i++) begin
      e[i] = mq.pop_front();
      mq.push_back(d[i]);
    end
    start_i = 1'b1;
    kind_i = k;
    len_i = n[7:0];
    data_i = d;
    @(negedge mclk_i);
    start_i = 1'b0;
    cmp_out("busy", 109'h1, 109'(busy_o));
    for (t = 0; t < 2000 && done_o !== 1'b1; t++) begin
      if (tap.tdo_oe_n === 1'b0) seen = 1'b1;
      else if (seen && k == bst_pkg::KIND_IR) begin
        seen = 1'b0;
        cmp_out("ir_hold", 109'(ir_old), 109'(ir_o));
      end
      @(negedge mclk_i);
    end
    cmp_out("done", 109'h1, 109'(done_o));
    if (k == bst_pkg::KIND_RESET) begin
      m_ir = `BST_OP_IDCODE;
      m_drive[108] = 1'b1;
    end else if (k == bst_pkg::KIND_IR) m_ir = {mq[2], mq[1], mq[0]};
    else if (m_ir inside {`BST_OP_EXTEST, `BST_OP_SAMPLE_Z, `BST_OP_SAMPLE_PRELOAD})
      for (int i = 0; i < 109; i++) m_drive[i] = mq[i];
    if (k != bst_pkg::KIND_RESET) cmp_scan("rx", e, rx_data_o);
    // Bus-enable and extest outputs trail the instruction update by one clock
    repeat (2) @(negedge mclk_i);
    check_out();
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    m_ir = `BST_OP_IDCODE;
    m_drive = 109'h1 << 108;
    check_out();
    scan(bst_pkg::KIND_RESET, 0, '0);
    scan(bst_pkg::KIND_DR, 40, rnd());
    foreach (OPS[i]) begin
      scan(bst_pkg::KIND_IR, 3, 128'(OPS[i]));
      pin_ring_i = 109'(rnd());
      scan(bst_pkg::KIND_DR, 128, rnd());
    end
    scan(bst_pkg::KIND_RESET, 0, '0);
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    m_drive = 109'h1 << 108;
    check_out();
    // Reset leaves the port in Test-Logic-Reset; scans expect Run-Test/Idle
    scan(bst_pkg::KIND_RESET, 0, '0);
    scan(bst_pkg::KIND_DR, 32, rnd());
    stop_test();
  end
  // About three times the length of the whole sequence
  initial begin
    #3000000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
